// File: hdl/bte_check.v
// receive-side tlp error classification and digest regeneration
// What this block does
// (R01) forwarded digest checked, fresh digest substituted on pass
// (R02) mismatch: inverted digest, flag set, nonfatal message
// (R03) own and consumed packets: digest ignored, request done
// (R04) link and external errors reported to external root
// (R05) phy symbol errors correctable, training errors uncorrectable
// (R06) nullified packet with inverted crc silently dropped
// (R07) link crc, sequence, dllp, replay errors correctable
// (R08) flow init and bad ack sequence uncorrectable
// (R09) completion at external endpoint is nonfatal error
// (R10) no flow control, overflow or consumed digest checks
// (R11) malformed checks at ingress only, fatal
// (R12) length checked against programmed max payload
// (R13) io/cfg reads: length 1, tc0, 4/3 dwords
// (R14) io/cfg writes: length 1, tc0, 5/4 dwords
// (R15) memory read: 3/4 or 4/5 dwords
// (R16) memory write: length plus 4/3 or 5/4
// (R17) completion with data: length plus 4/3, bounded
// (R18) message: length plus 5/4, bounded
// (R19) listed message kinds need traffic class zero
// (R20) no bar hit or type 1 config is unsupported
// (R21) power state write flags the opposite side
// (R22) d3hot side drops all but config and turn-off
// (R23) digest flag sticky, one message per bad packet
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`include "bte_defines.vh"

module bte_check (
  input  wire        i_clk,
  input  wire        i_arst_n,
  // ahb-lite slave
  input  wire        i_hsel,
  input  wire [7:0]  i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output wire [31:0] o_hrdata,
  output wire        o_hreadyout,
  output wire        o_hresp,
  // per-packet summary, one cycle at end of packet
  input  wire        i_tlp_end,
  input  wire        i_tlp_side,
  input  wire        i_tlp_ingress,
  input  wire        i_tlp_forward,
  input  wire [1:0]  i_tlp_fmt,
  input  wire [4:0]  i_tlp_type,
  input  wire [2:0]  i_tlp_tc,
  input  wire [1:0]  i_tlp_attr,
  input  wire [9:0]  i_tlp_len,
  input  wire [10:0] i_tlp_dw_cnt,
  input  wire        i_tlp_digest,
  input  wire [7:0]  i_tlp_msg_code,
  input  wire        i_tlp_bar_hit,
  input  wire        i_tlp_nullified,
  input  wire        i_tlp_lcrc_inv_match,
  input  wire [31:0] i_ecrc_rx,
  input  wire [31:0] i_ecrc_orig_calc,
  input  wire [31:0] i_ecrc_fresh,
  // link events, one-cycle pulses
  input  wire [3:0]  i_phy_cor_err,
  input  wire        i_phy_train_err,
  input  wire [4:0]  i_dll_cor_err,
  input  wire [1:0]  i_dll_uncor_err,
  // packet verdict
  output wire        o_tlp_done,
  output wire        o_tlp_drop,
  output wire        o_tlp_ur,
  output wire        o_tlp_malformed,
  output wire        o_ecrc_valid,
  output wire [31:0] o_ecrc_value,
  // error message request
  output wire        o_msg_valid,
  output wire [1:0]  o_msg_class,
  output wire        o_msg_to_ext,
  // per side: 0 internal, 1 external
  output wire [1:0]  o_tx_allow
);

  reg  [7:0]  ctrl_reg;
  reg  [3:0]  power_reg;
  reg  [1:0]  status_reg;
  reg  [1:0]  interrupt_status_reg_reg;
  reg  [3:0]  errseen_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg  [31:0] hrdata_reg;
  reg         hreadyout_reg;
  reg         done_reg;
  reg         drop_reg;
  reg         ur_reg;
  reg         malf_reg;
  reg         ecrc_valid_reg;
  reg  [31:0] ecrc_value_reg;
  reg         msg_valid_reg;
  reg  [1:0]  msg_class_reg;
  reg         msg_to_ext_reg;
  reg  [1:0]  tx_allow_reg;

  wire        addr_ok  = i_hsel & i_htrans[1] & i_hready;
  wire        wr_now   = wr_pend_reg;
  wire        wr_ctrl  = wr_now & (wr_addr_reg == `BTE_OFF_CTRL);
  wire        wr_power = wr_now & (wr_addr_reg == `BTE_OFF_POWER);
  wire        wr_stat  = wr_now & (wr_addr_reg == `BTE_OFF_STATUS);
  wire        wr_ints  = wr_now & (wr_addr_reg == `BTE_OFF_INTERRUPT_STATUS_REG);
  wire        wr_errs  = wr_now & (wr_addr_reg == `BTE_OFF_ERRSEEN);

  // packet decode
  wire        has_data = i_tlp_fmt[1];
  wire        hdr4     = i_tlp_fmt[0];
  wire        is_mem   = (i_tlp_type == `BTE_TYPE_MEM) |
                         (i_tlp_type == `BTE_TYPE_MEMLK);
  wire        is_io    = (i_tlp_type == `BTE_TYPE_IO);
  wire        is_cfg0  = (i_tlp_type == `BTE_TYPE_CFG0);
  wire        is_cfg1  = (i_tlp_type == `BTE_TYPE_CFG1);
  wire        is_cfg   = is_cfg0 | is_cfg1;
  wire        is_cpl   = (i_tlp_type == `BTE_TYPE_CPL);
  wire        is_msg   = (i_tlp_type[4:3] == 2'b10);
  wire [10:0] len_dw   = (i_tlp_len == 10'h000) ? 11'h400 :
                         {1'b0, i_tlp_len};
  wire [2:0]  mps_code = i_tlp_side ? ctrl_reg[`BTE_CTRL_MPS_EXT] :
                                      ctrl_reg[`BTE_CTRL_MPS_INT];
  wire [10:0] mps_dw   = (mps_code > 3'h5) ? 11'h400 :
                         (`BTE_MPS_BASE_DW << mps_code);
  wire        side_d3  = i_tlp_side ?
                         (power_reg[`BTE_PWR_EXT] == `BTE_D3HOT) :
                         (power_reg[`BTE_PWR_INT] == `BTE_D3HOT);
  wire        nfe_side = i_tlp_side ? ctrl_reg[`BTE_CTRL_NFE_EXT] :
                                      ctrl_reg[`BTE_CTRL_NFE_INT];

  // messages that may only travel on traffic class zero
  wire        msg_tc0  = (i_tlp_msg_code[7:3] == 5'h04) |
                         (i_tlp_msg_code[7:2] == 6'h0c) |
                         (i_tlp_msg_code == `BTE_MSG_UNLOCK) |
                         (i_tlp_msg_code == `BTE_MSG_PM_ACT) |
                         (i_tlp_msg_code == `BTE_MSG_PM_PME) |
                         (i_tlp_msg_code == `BTE_MSG_TURN_OFF) |
                         (i_tlp_msg_code == `BTE_MSG_PME_ACK) |
                         (i_tlp_msg_code == `BTE_MSG_SLOT_PWR);

  reg  [10:0] exp_dw;
  reg         malformed;
  reg  [10:0] msg_len;

  always @* begin
    exp_dw    = i_tlp_dw_cnt;
    msg_len   = has_data ? len_dw : 11'h000;
    malformed = (len_dw > mps_dw) & has_data; // R12
    if (is_io | is_cfg) begin
      malformed = malformed | (len_dw != 11'h001) |
                  (i_tlp_tc != 3'h0) | (i_tlp_attr != 2'h0); // R13 R14
      if (has_data)
        exp_dw = i_tlp_digest ? `BTE_DW_WR_D : `BTE_DW_WR_ND; // R14
      else
        exp_dw = i_tlp_digest ? `BTE_DW_RD_D : `BTE_DW_RD_ND; // R13
    end else if (is_mem & ~has_data) begin
      if (hdr4)
        exp_dw = i_tlp_digest ? `BTE_MRD64_D : `BTE_MRD64_ND; // R15
      else
        exp_dw = i_tlp_digest ? `BTE_MRD32_D : `BTE_MRD32_ND; // R15
    end else if (is_mem) begin
      if (hdr4)
        exp_dw = len_dw + (i_tlp_digest ? 11'd5 : 11'd4); // R16
      else
        exp_dw = len_dw + (i_tlp_digest ? 11'd4 : 11'd3); // R16
    end else if (is_cpl & has_data) begin
      exp_dw    = len_dw + (i_tlp_digest ? 11'd4 : 11'd3); // R17
      malformed = malformed | (i_tlp_dw_cnt >
                  mps_dw + (i_tlp_digest ? 11'd4 : 11'd3)); // R17
    end else if (is_msg) begin
      exp_dw    = msg_len + (i_tlp_digest ? 11'd5 : 11'd4); // R18
      malformed = malformed | (i_tlp_dw_cnt >
                  mps_dw + (i_tlp_digest ? 11'd5 : 11'd4)); // R18
      malformed = malformed | (msg_tc0 & (i_tlp_tc != 3'h0)); // R19
    end
    malformed = malformed | (exp_dw != i_tlp_dw_cnt);
  end

  // nullified packets: inverted crc means a clean discard
  wire        null_ok  = i_tlp_nullified & i_tlp_lcrc_inv_match;
  wire        null_bad = i_tlp_nullified & ~i_tlp_lcrc_inv_match;
  wire        tlp_live = i_tlp_end & ~i_tlp_nullified;
  wire        bad_form = tlp_live & i_tlp_ingress & malformed; // R11
  wire        d3_drop  = tlp_live & side_d3 & ~is_cfg &
                         ~(is_msg & (i_tlp_msg_code ==
                           `BTE_MSG_TURN_OFF)); // R22
  wire        ur_hit   = tlp_live & ~bad_form & (d3_drop | is_cfg1 |
                         ((is_mem | is_io) & ~i_tlp_bar_hit)); // R20 R22
  // only completions are unexpected at the external endpoint
  wire        unexp    = tlp_live & ~bad_form & i_tlp_side & is_cpl; // R09
  // digest checked only on forwarded packets, never consumed ones
  wire        ecrc_chk = tlp_live & ~bad_form & ~ur_hit &
                         i_tlp_forward & i_tlp_digest; // R01 R03 R10
  wire        ecrc_bad = ecrc_chk & (i_ecrc_rx != i_ecrc_orig_calc);

  wire        lnk_uncor = i_phy_train_err | (|i_dll_uncor_err); // R05 R08
  wire        lnk_cor   = (|i_phy_cor_err) | (|i_dll_cor_err) |
                          (i_tlp_end & null_bad); // R05 R06 R07
  wire        nf_ecrc   = ecrc_bad & nfe_side; // R02
  wire        nf_unexp  = unexp & ctrl_reg[`BTE_CTRL_NFE_EXT];

  // one message per cycle, highest severity first
  reg         msg_v;
  reg  [1:0]  msg_c;
  reg         msg_e;

  always @* begin
    msg_v = 1'b1;
    msg_c = `BTE_CLS_COR;
    msg_e = 1'b1; // R04
    if (bad_form) begin
      msg_c = `BTE_CLS_FATAL; // R11
      msg_e = i_tlp_side;
    end else if (lnk_uncor) begin
      msg_c = `BTE_CLS_UNCOR;
    end else if (nf_ecrc) begin
      msg_c = `BTE_CLS_NONFATAL;
      msg_e = i_tlp_side; // R02
    end else if (nf_unexp) begin
      msg_c = `BTE_CLS_NONFATAL; // R09
    end else if (lnk_cor) begin
      msg_c = `BTE_CLS_COR;
    end else begin
      msg_v = 1'b0;
    end
  end

  // register read mux
  reg  [31:0] rd_val;

  always @* begin
    case (i_haddr)
      `BTE_OFF_CTRL:    rd_val = {24'h000000, ctrl_reg};
      `BTE_OFF_POWER:   rd_val = {28'h0000000, power_reg};
      `BTE_OFF_STATUS:  rd_val = {30'h00000000, status_reg};
      `BTE_OFF_INTERRUPT_STATUS_REG:  rd_val = {30'h00000000, interrupt_status_reg_reg};
      `BTE_OFF_ERRSEEN: rd_val = {28'h0000000, errseen_reg};
      default:          rd_val = 32'h00000000;
    endcase
  end

  wire [3:0]  err_set = {bad_form, msg_v & (msg_c == `BTE_CLS_NONFATAL),
                         lnk_uncor, lnk_cor};
  wire [1:0]  dflag_set = {ecrc_bad & i_tlp_side,
                           ecrc_bad & ~i_tlp_side};
  wire [1:0]  pwr_wr_set = {wr_power, wr_power};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg       <= `BTE_CTRL_RST;
      power_reg      <= `BTE_PWR_RST;
      errseen_reg    <= 4'h0;
      wr_pend_reg    <= 1'b0;
      wr_addr_reg    <= 8'h00;
      hrdata_reg     <= 32'h00000000;
      hreadyout_reg  <= 1'b1;
      done_reg       <= 1'b0;
      drop_reg       <= 1'b0;
      ur_reg         <= 1'b0;
      malf_reg       <= 1'b0;
      ecrc_valid_reg <= 1'b0;
      ecrc_value_reg <= 32'h00000000;
      msg_valid_reg  <= 1'b0;
      msg_class_reg  <= 2'h0;
      msg_to_ext_reg <= 1'b0;
    end else begin
      wr_pend_reg   <= addr_ok & i_hwrite;
      wr_addr_reg   <= addr_ok ? i_haddr : wr_addr_reg;
      hreadyout_reg <= 1'b1;
      if (addr_ok & ~i_hwrite)
        hrdata_reg <= rd_val;
      if (wr_ctrl)
        ctrl_reg <= i_hwdata[7:0];
      if (wr_power)
        power_reg <= i_hwdata[3:0];
      errseen_reg <= (errseen_reg & ~({4{wr_errs}} & i_hwdata[3:0])) |
                     err_set;
      done_reg       <= i_tlp_end;
      drop_reg       <= i_tlp_end & (null_ok | null_bad | bad_form |
                        ur_hit); // R06 R22
      ur_reg         <= ur_hit; // R20
      malf_reg       <= bad_form;
      ecrc_valid_reg <= ecrc_chk;
      if (ecrc_chk)
        ecrc_value_reg <= ecrc_bad ? ~i_ecrc_fresh : i_ecrc_fresh; // R01 R02
      msg_valid_reg  <= msg_v; // R23
      msg_class_reg  <= msg_c;
      msg_to_ext_reg <= msg_e;
    end
  end

  // per-side sticky flags and transmit gate
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_side
      wire [1:0] side_pwr = (s == 1) ? power_reg[`BTE_PWR_EXT] :
                                       power_reg[`BTE_PWR_INT];
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          status_reg[s]   <= 1'b0;
          interrupt_status_reg_reg[s]   <= 1'b0;
          tx_allow_reg[s] <= 1'b1;
        end else begin
          // set wins over a same-cycle clear
          status_reg[s]   <= (status_reg[s] & ~(wr_stat & i_hwdata[s])) |
                             dflag_set[s]; // R02 R23
          // a power write changes both fields, so flags each opposite side
          interrupt_status_reg_reg[s]   <= (interrupt_status_reg_reg[s] & ~(wr_ints & i_hwdata[s])) |
                             pwr_wr_set[s]; // R21
          tx_allow_reg[s] <= (side_pwr != `BTE_D3HOT); // R22
        end
      end
    end
  endgenerate

  assign o_hrdata        = hrdata_reg;
  assign o_hreadyout     = hreadyout_reg;
  assign o_hresp         = 1'b0;
  assign o_tlp_done      = done_reg;
  assign o_tlp_drop      = drop_reg;
  assign o_tlp_ur        = ur_reg;
  assign o_tlp_malformed = malf_reg;
  assign o_ecrc_valid    = ecrc_valid_reg;
  assign o_ecrc_value    = ecrc_value_reg;
  assign o_msg_valid     = msg_valid_reg;
  assign o_msg_class     = msg_class_reg;
  assign o_msg_to_ext    = msg_to_ext_reg;
  assign o_tx_allow      = tx_allow_reg;

endmodule // bte_check

// File: hdl/bte_defines.vh
// constants for the bridge tlp error and digest check block
`ifndef BTE_DEFINES_VH
`define BTE_DEFINES_VH

// register byte offsets
`define BTE_OFF_CTRL      8'h00
`define BTE_OFF_POWER     8'h04
`define BTE_OFF_STATUS    8'h08
`define BTE_OFF_INTERRUPT_STATUS_REG    8'h0c
`define BTE_OFF_ERRSEEN   8'h10

// control register fields
`define BTE_CTRL_NFE_INT  0
`define BTE_CTRL_NFE_EXT  1
`define BTE_CTRL_MPS_INT  4:2
`define BTE_CTRL_MPS_EXT  7:5
`define BTE_CTRL_RST      8'h00

// power register fields and encodings
`define BTE_PWR_INT       1:0
`define BTE_PWR_EXT       3:2
`define BTE_PWR_RST       4'h0
`define BTE_D3HOT         2'h3

// tlp fmt/type decode
`define BTE_TYPE_MEM      5'h00
`define BTE_TYPE_MEMLK    5'h01
`define BTE_TYPE_IO       5'h02
`define BTE_TYPE_CFG0     5'h04
`define BTE_TYPE_CFG1     5'h05
`define BTE_TYPE_CPL      5'h0a

// message codes that must use traffic class zero
`define BTE_MSG_UNLOCK    8'h00
`define BTE_MSG_PM_ACT    8'h14
`define BTE_MSG_PM_PME    8'h18
`define BTE_MSG_TURN_OFF  8'h19
`define BTE_MSG_PME_ACK   8'h1b
`define BTE_MSG_SLOT_PWR  8'h50

// error message classes
`define BTE_CLS_COR       2'h0
`define BTE_CLS_UNCOR     2'h1
`define BTE_CLS_NONFATAL  2'h2
`define BTE_CLS_FATAL     2'h3

// doubleword counts for packet length checks
`define BTE_DW_RD_D       11'd4
`define BTE_DW_RD_ND      11'd3
`define BTE_DW_WR_D       11'd5
`define BTE_DW_WR_ND      11'd4
`define BTE_MRD32_D       11'd3
`define BTE_MRD32_ND      11'd4
`define BTE_MRD64_D       11'd4
`define BTE_MRD64_ND      11'd5
`define BTE_MPS_BASE_DW   11'd32

`endif

// File: testbench/bte_check_props.sv
// port-level assertions for the tlp error and digest check block
module bte_check_props (
  input wire        i_clk,
  input wire        i_arst_n,
  input wire        i_tlp_end,
  input wire        i_tlp_side,
  input wire        i_tlp_ingress,
  input wire        i_tlp_forward,
  input wire        i_tlp_digest,
  input wire        i_tlp_nullified,
  input wire        i_tlp_lcrc_inv_match,
  input wire [31:0] i_ecrc_rx,
  input wire [31:0] i_ecrc_orig_calc,
  input wire [31:0] i_ecrc_fresh,
  input wire [3:0]  i_phy_cor_err,
  input wire        i_phy_train_err,
  input wire [4:0]  i_dll_cor_err,
  input wire [1:0]  i_dll_uncor_err,
  input wire        o_tlp_drop,
  input wire        o_tlp_malformed,
  input wire        o_ecrc_valid,
  input wire [31:0] o_ecrc_value,
  input wire        o_msg_valid,
  input wire [1:0]  o_msg_class,
  input wire        o_msg_to_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  wire no_unc = !i_phy_train_err && i_dll_uncor_err == 2'h0;
  wire no_ev  = no_unc && i_phy_cor_err == 4'h0 && i_dll_cor_err == 5'h0;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_fwd;
    i_tlp_end && i_tlp_forward && i_tlp_digest;
  endsequence
  sequence s_null;
    i_tlp_end && i_tlp_nullified && i_tlp_lcrc_inv_match;
  endsequence
  a_digest_pass: assert property (
    s_fwd ##0 i_ecrc_rx == i_ecrc_orig_calc |=> o_ecrc_valid &&
    o_ecrc_value == $past(i_ecrc_fresh)) else $error("digest not fresh");
  a_digest_bad: assert property (
    s_fwd ##0 i_ecrc_rx != i_ecrc_orig_calc |=> o_ecrc_valid &&
    o_ecrc_value == ~$past(i_ecrc_fresh)) else $error("digest not inverted");
  a_consumed_digest: assert property (
    i_tlp_end && !i_tlp_forward |=> !o_ecrc_valid)
    else $error("digest checked on consumed packet");
  a_null_silent: assert property (
    s_null ##0 no_ev |=> o_tlp_drop && !o_msg_valid)
    else $error("nullified packet not silently dropped");
  a_link_cor: assert property (
    !i_tlp_end && no_unc && (|{i_dll_cor_err, i_phy_cor_err}) |=>
    o_msg_valid && o_msg_class == 2'h0 && o_msg_to_ext) else $error("cor");
  a_train_uncor: assert property (
    !i_tlp_end && i_phy_train_err |=> o_msg_valid &&
    o_msg_class == 2'h1 && o_msg_to_ext) else $error("training uncor");
  a_ack_uncor: assert property (
    !i_tlp_end && (|i_dll_uncor_err) |=> o_msg_valid &&
    o_msg_class == 2'h1 && o_msg_to_ext) else $error("link uncor");
  a_mal_fatal: assert property (
    o_tlp_malformed |-> o_tlp_drop && o_msg_valid && o_msg_class == 2'h3
    && o_msg_to_ext == $past(i_tlp_side)) else $error("malformed not fatal");
  a_egress_nocheck: assert property (
    i_tlp_end && !i_tlp_ingress |=> !o_tlp_malformed)
    else $error("malformed check away from ingress");
endmodule // bte_check_props

bind bte_check bte_check_props u_props (
  .i_clk, .i_arst_n, .i_tlp_end, .i_tlp_side, .i_tlp_ingress,
  .i_tlp_forward, .i_tlp_digest, .i_tlp_nullified, .i_tlp_lcrc_inv_match,
  .i_ecrc_rx, .i_ecrc_orig_calc, .i_ecrc_fresh, .i_phy_cor_err,
  .i_phy_train_err, .i_dll_cor_err, .i_dll_uncor_err, .o_tlp_drop,
  .o_tlp_malformed, .o_ecrc_valid, .o_ecrc_value, .o_msg_valid,
  .o_msg_class, .o_msg_to_ext);

// File: testbench/bte_pkt_src.sv
// far-side packet source: one summary per received packet
module bte_pkt_src (
  input  wire         i_clk,
  output logic        o_end,
  output logic [6:0]  o_flags,
  output logic [1:0]  o_fmt,
  output logic [4:0]  o_type,
  output logic [9:0]  o_len,
  output logic [10:0] o_dw,
  output logic [31:0] o_erx,
  output logic [31:0] o_eorig,
  output logic [31:0] o_efresh
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {o_end, o_flags, o_fmt, o_type, o_len, o_dw} = '0;
    {o_erx, o_eorig, o_efresh} = '0;
  end
  // flags: side, ingress, forward, digest, bar hit, nullified, lcrc inverted
  task automatic send(input logic [6:0] f, input logic [1:0] fm,
      input logic [4:0] ty, input logic [9:0] ln, input logic [10:0] dw,
      input logic [31:0] rx, input logic [31:0] orig, input logic [31:0] fr);
    @(posedge i_clk);
    {o_flags, o_fmt, o_type, o_len, o_dw} <= {f, fm, ty, ln, dw};
    {o_erx, o_eorig, o_efresh} <= {rx, orig, fr};
    o_end <= 1'b1;
    @(posedge i_clk);
    o_end <= 1'b0;
    // summary is only valid with the end pulse, so scramble its flags, dword count and digests afterwards
    {o_flags, o_dw, o_erx, o_eorig, o_efresh} <= ~{f, dw, rx, orig, fr};
  endtask
endmodule // bte_pkt_src

// File: testbench/tb_top.sv
// self-checking bench for the tlp error and digest check block
`include "bte_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_arst_n, i_hsel, i_hwrite, pend;
  logic [1:0]  i_htrans, o_msg_class, o_tx_allow, fm;
  logic [2:0]  i_hsize;
  logic [7:0]  i_haddr;
  logic [31:0] i_hwdata, o_hrdata, o_ecrc_value, erx, eor, efr, fr;
  logic        o_hreadyout, o_hresp, o_tlp_done, o_tlp_drop, o_tlp_ur;
  logic        o_tlp_malformed, o_ecrc_valid, o_msg_valid, o_msg_to_ext;
  logic [11:0] ev;
  logic [12:0] xt;
  logic [6:0]  fl;
  logic [4:0]  ty;
  logic [9:0]  ln;
  logic [10:0] dw;
  int          fails = 0;
  int          check_count = 0;
  bte_pkt_src src_u (.i_clk, .o_end(pend), .o_flags(fl), .o_fmt(fm),
    .o_type(ty), .o_len(ln), .o_dw(dw), .o_erx(erx), .o_eorig(eor),
    .o_efresh(efr));
  bte_check dut_u (.i_clk, .i_arst_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata,
    .o_hreadyout, .o_hresp, .i_tlp_end(pend), .i_tlp_side(fl[6]),
    .i_tlp_ingress(fl[5]), .i_tlp_forward(fl[4]), .i_tlp_digest(fl[3]),
    .i_tlp_bar_hit(fl[2]), .i_tlp_nullified(fl[1]),
    .i_tlp_lcrc_inv_match(fl[0]), .i_tlp_fmt(fm), .i_tlp_type(ty),
    .i_tlp_tc(xt[12:10]), .i_tlp_attr(xt[9:8]), .i_tlp_len(ln),
    .i_tlp_dw_cnt(dw), .i_tlp_msg_code(xt[7:0]), .i_ecrc_rx(erx),
    .i_ecrc_orig_calc(eor),
    .i_ecrc_fresh(efr), .i_phy_cor_err(ev[3:0]), .i_phy_train_err(ev[4]),
    .i_dll_cor_err(ev[9:5]), .i_dll_uncor_err(ev[11:10]), .o_tlp_done,
    .o_tlp_drop, .o_tlp_ur, .o_tlp_malformed, .o_ecrc_valid, .o_ecrc_value,
    .o_msg_valid, .o_msg_class, .o_msg_to_ext, .o_tx_allow);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    {i_hsel, i_htrans, i_haddr, i_hwrite} <= {1'b1, 2'b10, a, w};
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    {i_hsel, i_htrans, i_hwdata} <= {1'b0, 2'b00, d};
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    q = o_hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("register", e, q);
    chk("hresp", 32'h0, {31'h0, o_hresp});
  endtask
  // tc, attr and message code beside the packet summary
  task automatic ext_hdr(input logic [12:0] x);
    @(posedge i_clk);
    xt <= x;
  endtask
  // e: drop, unsupported, malformed, message, message class
  task automatic pkt(input logic [6:0] f, input logic [1:0] m,
      input logic [4:0] t, input logic [9:0] l, input logic [10:0] d,
      input logic bad, input logic [5:0] e);
    fr = fr + 32'h01030507;
    src_u.send(f, m, t, l, d, 32'h600d, 32'h600d ^ {31'h0, bad}, fr);
    #1;
    chk("verdict", {26'h0, e}, {26'h0, o_tlp_drop, o_tlp_ur, o_tlp_malformed,
      o_msg_valid, o_msg_class & {2{o_msg_valid}}});
    chk("done", 32'h1, {31'h0, o_tlp_done});
  endtask
  task automatic t_reset;
    for (int a = 0; a < 24; a += 4)
      reg_is(8'(a), 32'h0);
    chk("tx allow", 32'h3, {30'h0, o_tx_allow});
  endtask
  task automatic t_link;
    for (int i = 0; i < 12; i++) begin
      @(posedge i_clk);
      ev <= 12'h1 << i;
      @(posedge i_clk);
      ev <= 12'h0;
      #1;
      chk("link msg", (i == 4 || i > 9) ? 32'h5 : 32'h4,
        {29'h0, o_msg_valid, o_msg_class});
      chk("link root", 32'h1, {31'h0, o_msg_to_ext});
    end
    reg_is(`BTE_OFF_ERRSEEN, 32'h3);
  endtask
  task automatic t_ecrc;
    wr(`BTE_OFF_CTRL, 32'h3);
    pkt(7'h3c, 2'b10, 5'h00, 10'd1, 11'd5, 1'b0, 6'h00);
    chk("digest", fr, o_ecrc_value);
    pkt(7'h7c, 2'b10, 5'h00, 10'd1, 11'd5, 1'b1, 6'h06);
    chk("digest", ~fr, o_ecrc_value);
    chk("root", 32'h1, {31'h0, o_msg_to_ext});
    pkt(7'h7c, 2'b10, 5'h00, 10'd1, 11'd5, 1'b0, 6'h00);
    reg_is(`BTE_OFF_STATUS, 32'h2);
    wr(`BTE_OFF_STATUS, 32'h2);
    reg_is(`BTE_OFF_STATUS, 32'h0);
    wr(`BTE_OFF_CTRL, 32'h0);
    pkt(7'h3c, 2'b10, 5'h00, 10'd1, 11'd5, 1'b1, 6'h00);
    chk("digest", ~fr, o_ecrc_value);
    reg_is(`BTE_OFF_STATUS, 32'h1);
  endtask
  task automatic t_pkt;
    wr(`BTE_OFF_CTRL, 32'h3);
    pkt(7'h24, 2'b10, 5'h00, 10'd1, 11'd4, 1'b0, 6'h00);
    pkt(7'h24, 2'b10, 5'h00, 10'd1, 11'd5, 1'b0, 6'h2f);
    pkt(7'h04, 2'b10, 5'h00, 10'd1, 11'd5, 1'b0, 6'h00);
    pkt(7'h24, 2'b00, 5'h02, 10'd1, 11'd3, 1'b0, 6'h00);
    pkt(7'h24, 2'b00, 5'h02, 10'd2, 11'd3, 1'b0, 6'h2f);
    pkt(7'h2c, 2'b10, 5'h04, 10'd1, 11'd5, 1'b0, 6'h00);
    pkt(7'h2c, 2'b10, 5'h04, 10'd1, 11'd4, 1'b0, 6'h2f);
    pkt(7'h24, 2'b00, 5'h00, 10'd1, 11'd4, 1'b0, 6'h00);
    pkt(7'h2c, 2'b00, 5'h00, 10'd1, 11'd4, 1'b0, 6'h2f);
    pkt(7'h24, 2'b10, 5'h00, 10'd33, 11'd36, 1'b0, 6'h2f);
    pkt(7'h64, 2'b10, 5'h0a, 10'd1, 11'd4, 1'b0, 6'h06);
    pkt(7'h64, 2'b10, 5'h0a, 10'd1, 11'd5, 1'b0, 6'h2f);
  endtask
  task automatic t_ur;
    pkt(7'h20, 2'b10, 5'h00, 10'd1, 11'd4, 1'b0, 6'h30);
    pkt(7'h24, 2'b00, 5'h05, 10'd1, 11'd3, 1'b0, 6'h30);
    pkt(7'h27, 2'b10, 5'h00, 10'd1, 11'd4, 1'b0, 6'h20);
    pkt(7'h2c, 2'b10, 5'h00, 10'd1, 11'd5, 1'b1, 6'h00);
    chk("digest valid", 32'h0, {31'h0, o_ecrc_valid});
  endtask
  task automatic t_hdr;
    ext_hdr(13'h0400);
    pkt(7'h24, 2'b00, 5'h02, 10'd1, 11'd3, 1'b0, 6'h2f);
    pkt(7'h24, 2'b10, 5'h00, 10'd1, 11'd4, 1'b0, 6'h00);
    ext_hdr(13'h0420);
    pkt(7'h24, 2'b00, 5'h10, 10'd0, 11'd4, 1'b0, 6'h2f);
    ext_hdr(13'h047e);
    pkt(7'h24, 2'b00, 5'h10, 10'd0, 11'd4, 1'b0, 6'h00);
    ext_hdr(13'h0100);
    pkt(7'h24, 2'b10, 5'h04, 10'd1, 11'd4, 1'b0, 6'h2f);
    ext_hdr(13'h0000);
  endtask
  task automatic t_power;
    wr(`BTE_OFF_POWER, {28'h0, `BTE_D3HOT, 2'h0});
    @(posedge i_clk);
    #1;
    chk("tx allow", 32'h1, {30'h0, o_tx_allow});
    reg_is(`BTE_OFF_INTERRUPT_STATUS_REG, 32'h3);
    pkt(7'h64, 2'b10, 5'h00, 10'd1, 11'd4, 1'b0, 6'h30);
    pkt(7'h64, 2'b00, 5'h04, 10'd1, 11'd3, 1'b0, 6'h00);
    ext_hdr(13'h0019);
    pkt(7'h64, 2'b00, 5'h10, 10'd0, 11'd4, 1'b0, 6'h00);
    ext_hdr(13'h0020);
    pkt(7'h64, 2'b00, 5'h10, 10'd0, 11'd4, 1'b0, 6'h30);
    ext_hdr(13'h0000);
    wr(`BTE_OFF_INTERRUPT_STATUS_REG, 32'h3);
    wr(`BTE_OFF_POWER, 32'h0);
    reg_is(`BTE_OFF_INTERRUPT_STATUS_REG, 32'h3);
    chk("tx allow", 32'h3, {30'h0, o_tx_allow});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    repeat (4000) @(posedge i_clk);
    fails++;
    end_of_test();
  end
  initial begin
    {i_arst_n, i_hsel, i_hwrite, i_htrans, i_haddr, i_hwdata, ev, xt} = '0;
    i_hsize = 3'h2;
    fr = 32'h1111_0000;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_link();
    t_ecrc();
    t_pkt();
    t_ur();
    t_hdr();
    t_power();
    end_of_test();
  end
endmodule // tb_top
